// file: spcs_top.sv
module spcs_top (
   // clock and reset
   input wire logic MCLK,
   input wire logic SRST,
   // axi4-lite slave
   input wire logic [4:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [4:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // interrupt request and vector acknowledge
   output logic IRQ,
   input wire logic IRQ_ACK,
   // spi pins
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE,
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE,
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE,
   input wire logic SS_N_I
);
   spcs_pkg::spcs_control_a_role_rate_t control_a_role_rate_reg;
   spcs_pkg::spcs_control_b_buffer_mode_t control_b_buffer_mode_reg;
   spcs_pkg::spcs_state_t state_reg;
   logic [7:0] inten_reg;
   logic [3:0] sync1_reg, sync2_reg;
   logic sck_prev_reg;
   logic aw_full_reg, w_full_reg;
   logic [4:0] aw_addr_reg;
   logic [7:0] w_byte_reg;
   logic w_lane_reg;
   logic tflag_reg, wcol_reg, txc_reg, select_trigger_flag_reg, ovf_reg, arm_if_reg, arm_wc_reg;
   logic [7:0] tx_sh_reg, rx_sh_reg, txbuf_reg, rx1_reg, rx2_reg, rxlast_reg;
   logic txbuf_full_reg, sh_pend_reg, rx1_v_reg, rx2_v_reg;
   logic [3:0] edge_cnt_reg;
   logic [6:0] div_cnt_reg;
   logic sck_o_reg, dout_reg;
   logic sck_s, mosi_s, miso_s, ss_n_s;
   logic do_wr, wr_ok, aw_take, w_take, ar_take, rd_ok;
   logic [2:0] wr_idx, rd_idx;
   logic data_wr, data_rd, data_acc, flags_rd, wr_control_a_role_rate, wr_control_b_buffer_mode, wr_inten, wr_flags;
   logic bufm, is_master, lose_master, cpol, cpha, busy;
   logic [6:0] half;
   logic tick, sck_edge, edge_ev, lead, sample_ev, setup_ev, done, start_m, start_s;
   logic in_bit, rd_pop, r1v_a, r2v_a;
   logic [7:0] rx_new, tx_shift, flags_val, rd_val, r2_a;

   // first bit on the wire for the chosen bit order
   function automatic logic first_bit(input logic lsb, input logic [7:0] b);
      first_bit = lsb ? b[0] : b[7];
   endfunction

   // pins from the remote party: two flops before any logic reads them
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         sync1_reg <= 4'hf;
         sync2_reg <= 4'hf;
      end else begin
         sync1_reg <= {SCK_I, MOSI_I, MISO_I, SS_N_I};
         sync2_reg <= sync1_reg;
      end
   end
   assign {sck_s, mosi_s, miso_s, ss_n_s} = sync2_reg;

   // bus decode; a write executes once address and data are both held
   assign aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
   assign w_take = S_AXI_WVALID & S_AXI_WREADY;
   assign ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
   assign do_wr = aw_full_reg & w_full_reg & ~S_AXI_BVALID;
   assign wr_idx = aw_addr_reg[4:2];
   assign wr_ok = (aw_addr_reg[1:0] == 2'h0) && (wr_idx <= spcs_pkg::IDX_DATA);
   assign rd_idx = S_AXI_ARADDR[4:2];
   assign rd_ok = (S_AXI_ARADDR[1:0] == 2'h0) && (rd_idx <= spcs_pkg::IDX_DATA);
   assign wr_control_a_role_rate = do_wr & wr_ok & w_lane_reg & (wr_idx == spcs_pkg::IDX_CONTROL_A_ROLE_RATE);
   assign wr_control_b_buffer_mode = do_wr & wr_ok & w_lane_reg & (wr_idx == spcs_pkg::IDX_CONTROL_B_BUFFER_MODE);
   assign wr_inten = do_wr & wr_ok & w_lane_reg & (wr_idx == spcs_pkg::IDX_INTEN);
   assign wr_flags = do_wr & wr_ok & w_lane_reg & (wr_idx == spcs_pkg::IDX_FLAGS);
   assign data_wr = do_wr & wr_ok & w_lane_reg & (wr_idx == spcs_pkg::IDX_DATA);
   assign data_rd = ar_take & rd_ok & (rd_idx == spcs_pkg::IDX_DATA);
   assign flags_rd = ar_take & rd_ok & (rd_idx == spcs_pkg::IDX_FLAGS);
   assign data_acc = data_wr | data_rd;

   // write channels: address and data accepted in either order
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
         w_byte_reg <= 8'h00;
         w_lane_reg <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= spcs_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_addr_reg <= S_AXI_AWADDR;
         end
         if (w_take) begin
            w_byte_reg <= S_AXI_WDATA[7:0];
            w_lane_reg <= S_AXI_WSTRB[0];
         end
         aw_full_reg <= aw_take | (aw_full_reg & ~do_wr);
         w_full_reg <= w_take | (w_full_reg & ~do_wr);
         S_AXI_AWREADY <= ~(aw_take | (aw_full_reg & ~do_wr));
         S_AXI_WREADY <= ~(w_take | (w_full_reg & ~do_wr));
         if (do_wr) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? spcs_pkg::RESP_OKAY : spcs_pkg::RESP_SLVERR;
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // read value; interrupt enables of buffered mode read zero without it
   always_comb begin
      flags_val = 8'h00;
      if (bufm) begin
         flags_val[spcs_pkg::BIT_RXC] = rx2_v_reg;
         flags_val[spcs_pkg::BIT_TXC] = txc_reg;
         flags_val[spcs_pkg::BIT_DRE] = ~txbuf_full_reg;
         flags_val[spcs_pkg::BIT_SSI] = select_trigger_flag_reg;
         flags_val[spcs_pkg::BIT_LEG] = ovf_reg;
      end else begin
         flags_val[spcs_pkg::BIT_RXC] = tflag_reg;
         flags_val[spcs_pkg::BIT_TXC] = wcol_reg;
      end
      case (rd_idx)
         spcs_pkg::IDX_CONTROL_A_ROLE_RATE: rd_val = control_a_role_rate_reg;
         spcs_pkg::IDX_CONTROL_B_BUFFER_MODE: rd_val = control_b_buffer_mode_reg;
         spcs_pkg::IDX_INTEN: rd_val = bufm ? inten_reg : {7'h00, inten_reg[spcs_pkg::BIT_LEG]};
         spcs_pkg::IDX_FLAGS: rd_val = flags_val;
         spcs_pkg::IDX_DATA: rd_val = bufm ? rx2_reg : rxlast_reg;
         default: rd_val = 8'h00;
      endcase
   end

   // read channel: one read in flight, data registered with the answer
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= spcs_pkg::RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= ~(ar_take | (S_AXI_RVALID & ~S_AXI_RREADY));
         if (ar_take) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h00_0000, rd_ok ? rd_val : 8'h00};
            S_AXI_RRESP <= rd_ok ? spcs_pkg::RESP_OKAY : spcs_pkg::RESP_SLVERR;
         end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // role, clocking and edge classification
   assign bufm = control_b_buffer_mode_reg.buffered_op_on;
   assign is_master = control_a_role_rate_reg.enable & control_a_role_rate_reg.master;
   assign lose_master = is_master & ~ss_n_s & ~control_b_buffer_mode_reg.select_line_ignore;
   assign cpol = control_b_buffer_mode_reg.mode[1];
   assign cpha = control_b_buffer_mode_reg.mode[0];
   assign busy = (state_reg == spcs_pkg::ST_RUN);
   always_comb begin
      case (control_a_role_rate_reg.rate_divider)
         2'h0: half = spcs_pkg::HALF_C0;
         2'h1: half = spcs_pkg::HALF_C1;
         2'h2: half = spcs_pkg::HALF_C2;
         default: half = spcs_pkg::HALF_C3;
      endcase
      if (control_a_role_rate_reg.clock_double_sel) begin
         half = half >> 1;
      end
   end
   // master edges come from the divider, slave edges from the synced pin
   assign tick = busy & is_master & (div_cnt_reg == half - 7'h01);
   assign sck_edge = busy & ~control_a_role_rate_reg.master & (sck_s != sck_prev_reg);
   assign edge_ev = is_master ? tick : sck_edge;
   assign lead = ~edge_cnt_reg[0];
   assign sample_ev = edge_ev & (lead ^ cpha);
   assign setup_ev = edge_ev & ~(lead ^ cpha);
   assign done = edge_ev & (edge_cnt_reg == spcs_pkg::LAST_EDGE);
   assign in_bit = is_master ? miso_s : mosi_s;
   assign rx_new = ~sample_ev ? rx_sh_reg :
                   control_a_role_rate_reg.dord ? {in_bit, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], in_bit};
   assign tx_shift = control_a_role_rate_reg.dord ? {1'b0, tx_sh_reg[7:1]} : {tx_sh_reg[6:0], 1'b0};
   assign start_m = ~busy & is_master & ~lose_master & (sh_pend_reg | (bufm & txbuf_full_reg));
   assign start_s = ~busy & control_a_role_rate_reg.enable & ~control_a_role_rate_reg.master & ~ss_n_s;

   // configuration registers; hardware drop of master role wins a same-cycle write
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         control_a_role_rate_reg <= spcs_pkg::RST_CONTROL_A_ROLE_RATE;
         control_b_buffer_mode_reg <= spcs_pkg::RST_CONTROL_B_BUFFER_MODE;
         inten_reg <= spcs_pkg::RST_INTEN;
      end else begin
         if (wr_control_a_role_rate) begin
            control_a_role_rate_reg <= w_byte_reg;
         end
         if (lose_master) begin
            control_a_role_rate_reg.master <= 1'b0;
         end
         if (wr_control_b_buffer_mode) begin
            control_b_buffer_mode_reg <= w_byte_reg;
         end
         if (wr_inten) begin
            inten_reg <= w_byte_reg;
         end
      end
   end

   // transfer sequencer and shift engine
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state_reg <= spcs_pkg::ST_IDLE;
         edge_cnt_reg <= 4'h0;
         div_cnt_reg <= 7'h00;
         sck_prev_reg <= 1'b0;
         rx_sh_reg <= 8'h00;
      end else begin
         sck_prev_reg <= sck_s;
         div_cnt_reg <= (busy & is_master & ~tick) ? div_cnt_reg + 7'h01 : 7'h00;
         if (edge_ev) begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
            rx_sh_reg <= rx_new;
         end
         case (state_reg)
            spcs_pkg::ST_IDLE: begin
               edge_cnt_reg <= 4'h0;
               if (start_m | start_s) begin
                  state_reg <= spcs_pkg::ST_RUN;
                  sck_prev_reg <= cpol;
               end
            end
            spcs_pkg::ST_RUN: begin
               if (~control_a_role_rate_reg.enable | lose_master) begin
                  state_reg <= spcs_pkg::ST_IDLE;
               end else if (~control_a_role_rate_reg.master & ss_n_s) begin
                  state_reg <= spcs_pkg::ST_IDLE; // partial byte dropped
               end else if (done & control_a_role_rate_reg.master) begin
                  state_reg <= spcs_pkg::ST_IDLE;
               end
            end
            default: state_reg <= spcs_pkg::ST_IDLE;
         endcase
      end
   end

   // transmit shifter, transmit buffer and the data-out bit
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         tx_sh_reg <= 8'h00;
         txbuf_reg <= 8'h00;
         txbuf_full_reg <= 1'b0;
         sh_pend_reg <= 1'b0;
         dout_reg <= 1'b0;
      end else begin
         if (start_m | start_s) begin
            sh_pend_reg <= 1'b0;
            dout_reg <= first_bit(control_a_role_rate_reg.dord, tx_sh_reg);
         end
         if (setup_ev & (edge_cnt_reg != 4'h0) & ~done) begin
            tx_sh_reg <= tx_shift;
            dout_reg <= first_bit(control_a_role_rate_reg.dord, tx_shift);
         end
         if (done) begin
            if (bufm & txbuf_full_reg) begin
               tx_sh_reg <= txbuf_reg;
               txbuf_full_reg <= 1'b0;
               sh_pend_reg <= 1'b1;
               dout_reg <= first_bit(control_a_role_rate_reg.dord, txbuf_reg);
            end else begin
               tx_sh_reg <= rx_new; // next dummy is the last byte received
               dout_reg <= first_bit(control_a_role_rate_reg.dord, rx_new);
            end
         end
         if (data_wr) begin
            if (~bufm) begin
               if (~busy) begin
                  tx_sh_reg <= w_byte_reg;
                  sh_pend_reg <= control_a_role_rate_reg.master;
                  dout_reg <= first_bit(control_a_role_rate_reg.dord, w_byte_reg);
               end
            end else if (control_b_buffer_mode_reg.buffer_wait_receive & control_a_role_rate_reg.enable & ss_n_s & ~busy &
                         ~sh_pend_reg & ~txbuf_full_reg) begin
               tx_sh_reg <= w_byte_reg;
               sh_pend_reg <= 1'b1;
               dout_reg <= first_bit(control_a_role_rate_reg.dord, w_byte_reg);
            end else if (~txbuf_full_reg | done) begin
               txbuf_reg <= w_byte_reg; // a full buffer drops the byte
               txbuf_full_reg <= 1'b1;
            end
         end
         if (~control_a_role_rate_reg.enable) begin
            sh_pend_reg <= 1'b0;
         end
      end
   end

   // receive stages; a data read pops before a new byte is placed
   assign rd_pop = data_rd & bufm;
   assign r2v_a = rd_pop ? rx1_v_reg : rx2_v_reg;
   assign r1v_a = rd_pop ? 1'b0 : rx1_v_reg;
   assign r2_a = rd_pop ? rx1_reg : rx2_reg;
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rx1_reg <= 8'h00;
         rx2_reg <= 8'h00;
         rx1_v_reg <= 1'b0;
         rx2_v_reg <= 1'b0;
         rxlast_reg <= 8'h00;
         ovf_reg <= 1'b0;
      end else begin
         rx2_reg <= r2_a;
         rx2_v_reg <= r2v_a;
         rx1_v_reg <= r1v_a;
         if (wr_flags & bufm & w_byte_reg[spcs_pkg::BIT_RXC]) begin
            rx2_v_reg <= 1'b0;
            rx1_v_reg <= 1'b0;
         end
         if (data_rd) begin
            ovf_reg <= 1'b0;
         end
         if (done & ~bufm) begin
            rxlast_reg <= rx_new;
         end else if (done) begin
            if (~r2v_a) begin
               rx2_reg <= rx_new;
               rx2_v_reg <= 1'b1;
            end else if (~r1v_a) begin
               rx1_reg <= rx_new;
               rx1_v_reg <= 1'b1;
            end else begin
               ovf_reg <= 1'b1; // third byte with both stages full
            end
         end
      end
   end

   // flags; every hardware set wins over a same-cycle clear
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         tflag_reg <= 1'b0;
         wcol_reg <= 1'b0;
         txc_reg <= 1'b0;
         select_trigger_flag_reg <= 1'b0;
         arm_if_reg <= 1'b0;
         arm_wc_reg <= 1'b0;
      end else begin
         if (flags_rd & tflag_reg) begin
            arm_if_reg <= 1'b1;
         end else if (data_acc) begin
            arm_if_reg <= 1'b0;
         end
         if (flags_rd & wcol_reg) begin
            arm_wc_reg <= 1'b1;
         end else if (data_acc) begin
            arm_wc_reg <= 1'b0;
         end
         if (~bufm & (done | lose_master)) begin
            tflag_reg <= 1'b1;
         end else if (IRQ_ACK | (arm_if_reg & data_acc)) begin
            tflag_reg <= 1'b0;
         end
         if (data_wr & ~bufm & busy) begin
            wcol_reg <= 1'b1;
         end else if (arm_wc_reg & data_acc) begin
            wcol_reg <= 1'b0;
         end
         if (bufm & done & ~txbuf_full_reg) begin
            txc_reg <= 1'b1;
         end else if (wr_flags & w_byte_reg[spcs_pkg::BIT_TXC]) begin
            txc_reg <= 1'b0;
         end
         if (bufm & lose_master) begin
            select_trigger_flag_reg <= 1'b1;
         end else if (wr_flags & w_byte_reg[spcs_pkg::BIT_SSI]) begin
            select_trigger_flag_reg <= 1'b0;
         end
      end
   end

   // interrupt level and pin drivers, all registered
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         IRQ <= 1'b0;
         sck_o_reg <= 1'b0;
         SCK_OE <= 1'b0;
         MOSI_OE <= 1'b0;
         MISO_OE <= 1'b0;
      end else begin
         if (bufm) begin
            IRQ <= |({rx2_v_reg, txc_reg, ~txbuf_full_reg, select_trigger_flag_reg} & inten_reg[7:4]);
         end else begin
            IRQ <= inten_reg[spcs_pkg::BIT_LEG] & tflag_reg;
         end
         if (tick) begin
            sck_o_reg <= ~sck_o_reg;
         end else if (~busy) begin
            sck_o_reg <= cpol;
         end
         SCK_OE <= is_master & ~lose_master;
         MOSI_OE <= is_master & ~lose_master;
         MISO_OE <= control_a_role_rate_reg.enable & ~control_a_role_rate_reg.master & ~ss_n_s;
      end
   end
   assign SCK_O = sck_o_reg;
   assign MOSI_O = dout_reg;
   assign MISO_O = dout_reg;
endmodule // spcs_top

// file: spcs_pkg.sv
package spcs_pkg;
   // register indices; byte address is four times the index
   localparam logic [2:0] IDX_CONTROL_A_ROLE_RATE = 3'h0;
   localparam logic [2:0] IDX_CONTROL_B_BUFFER_MODE = 3'h1;
   localparam logic [2:0] IDX_INTEN = 3'h2;
   localparam logic [2:0] IDX_FLAGS = 3'h3;
   localparam logic [2:0] IDX_DATA = 3'h4;
   localparam int ADDR_W = 5;
   // reset values
   localparam logic [7:0] RST_CONTROL_A_ROLE_RATE = 8'h00;
   localparam logic [7:0] RST_CONTROL_B_BUFFER_MODE = 8'h00;
   localparam logic [7:0] RST_INTEN = 8'h00;
   // field positions in interrupt_enable and interrupt_flag_status
   localparam int BIT_RXC = 7;
   localparam int BIT_TXC = 6;
   localparam int BIT_DRE = 5;
   localparam int BIT_SSI = 4;
   localparam int BIT_LEG = 0;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // sck divisors of the peripheral clock, and half periods in cycles
   localparam int DIV_C0 = 4;
   localparam int DIV_C1 = 16;
   localparam int DIV_C2 = 64;
   localparam int DIV_C3 = 128;
   localparam logic [6:0] HALF_C0 = 7'(DIV_C0 / 2);
   localparam logic [6:0] HALF_C1 = 7'(DIV_C1 / 2);
   localparam logic [6:0] HALF_C2 = 7'(DIV_C2 / 2);
   localparam logic [6:0] HALF_C3 = 7'(DIV_C3 / 2);
   localparam logic [3:0] LAST_EDGE = 4'hf;
   // control_a_role_rate layout
   typedef struct packed {
      logic rsv7;
      logic dord;
      logic master;
      logic clock_double_sel;
      logic rsv3;
      logic [1:0] rate_divider;
      logic enable;
   } spcs_control_a_role_rate_t;
   // control_b_buffer_mode layout
   typedef struct packed {
      logic buffered_op_on;
      logic buffer_wait_receive;
      logic [2:0] rsv;
      logic select_line_ignore;
      logic [1:0] mode;
   } spcs_control_b_buffer_mode_t;
   typedef enum logic {ST_IDLE, ST_RUN} spcs_state_t;
endpackage

// file: spcs_top_sva.sv
module spcs_top_sva (
   // clock and reset
   input wire logic MCLK,
   input wire logic SRST,
   // bus handshakes
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // spi pins
   input wire logic SCK_OE,
   input wire logic MOSI_OE,
   input wire logic MISO_OE,
   input wire logic SS_N_I
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data changed before taken");
   // both halves taken together: response two edges later
   property p_wr_answer;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID |-> ##2 S_AXI_BVALID;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");
   property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h0; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late or wide");
   property p_ar_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
   a_ar_block: assert property (p_ar_block) else $error("address accepted while read pending");
   property p_oe_pair; SCK_OE == MOSI_OE; endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("clock and data drive disagree");
   property p_role_excl; MISO_OE |-> !SCK_OE; endproperty
   a_role_excl: assert property (p_role_excl) else $error("master and slave drive at once");
   // sync latency is two flops plus the output register
   property p_ss_halt; SS_N_I [*5] |-> !MISO_OE; endproperty
   a_ss_halt: assert property (p_ss_halt) else $error("slave drives while deselected");
endmodule // spcs_top_sva
bind spcs_top spcs_top_sva u_sva (.MCLK(MCLK), .SRST(SRST), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .SCK_OE(SCK_OE), .MOSI_OE(MOSI_OE), .MISO_OE(MISO_OE), .SS_N_I(SS_N_I));

// file: spcs_peer.sv
module spcs_peer (
   // serial lines and mode
   input wire logic sck,
   input wire logic mosi,
   input wire logic [1:0] mode,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // sample edge is rising for modes 0 and 3, falling for 1 and 2
   always @(sck) begin
      if (sck === (mode[1] == mode[0])) begin
         rx_byte <= {rx_byte[6:0], mosi};
         cnt <= cnt + 1;
      end
   end
   // msb first, moved on right after each sample
   assign miso = tx_byte[7 - (cnt % 8)];
endmodule // spcs_peer

// file: tb_spcs_top.sv
module tb_spcs_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, srst = 1'b1, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic [1:0] bresp, rresp, mode = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, irq_ack = 1'b0, ss_n = 1'b1;
   logic sck, sck_oe, mosi, mosi_oe, miso, miso_o, miso_oe;
   logic [7:0] rx;
   int errors = 0, checks_done = 0;
   always #20 mclk = ~mclk;
   spcs_top DUT (.MCLK(mclk), .SRST(srst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .IRQ(irq), .IRQ_ACK(irq_ack), .SCK_I(sck), .SCK_O(sck), .SCK_OE(sck_oe),
      .MOSI_I(mosi), .MOSI_O(mosi), .MOSI_OE(mosi_oe), .MISO_I(miso), .MISO_O(miso_o), .MISO_OE(miso_oe),
      .SS_N_I(ss_n));
   spcs_peer u_peer (.sck(sck), .mosi(mosi), .mode(mode), .tx_byte(8'hc3), .miso(miso), .rx_byte(rx));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // address and data offered together, each released when taken
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      int n;
      @(posedge mclk);
      {awaddr, wdata, awv, wv, bready} <= {a, 24'h0, d, 3'b111};
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) begin errors++; summarize(); end
   endtask
   task automatic rd(input logic [4:0] a);
      int n;
      @(posedge mclk);
      {araddr, arv, rready} <= {a, 2'b11};
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (arready) arv <= 1'b0;
         if (rvalid) break;
      end
      got = rdata;
      rready <= 1'b0;
      if (n == 50) begin errors++; summarize(); end
   endtask
   task automatic poll(input int b);
      int n;
      for (n = 0; n < 400; n++) begin
         rd(5'h0c);
         if (got[b] === 1'b1) break;
      end
      if (n == 400) begin errors++; summarize(); end
   endtask
   task automatic t_reset();
      int i;
      for (i = 0; i < 4; i++) begin rd(5'(i * 4)); chk("reset value", 32'h0, got); end
      rd(5'h14);
      chk("unmapped resp", 32'(spcs_pkg::RESP_SLVERR), 32'(rresp));
      chk("pins idle", 32'h0, 32'(sck_oe));
      $display("test reset done");
   endtask
   // every rate code with a different mode; code 3 also doubles the clock
   task automatic t_rates();
      int c, h, n;
      int div[4] = '{4, 16, 64, 128};
      for (c = 0; c < 4; c++) begin
         mode = 2'(c);
         wr(5'h04, 8'(c));
         wr(5'h08, 8'h01);
         wr(5'h00, {2'b00, 1'b1, c == 3, 1'b0, 2'(c), 1'b1});
         chk("sck idle", 32'(mode[1]), 32'(sck));
         wr(5'h10, 8'h90 + 8'(c));
         for (n = 0; n < 300 && sck === mode[1]; n++) @(posedge mclk);
         for (h = 0; h < 300 && sck !== mode[1]; h++) @(posedge mclk);
         chk("half period", (c == 3) ? div[c] / 4 : div[c] / 2, h);
         poll(7);
         chk("peer byte", 8'h90 + 8'(c), rx);
         chk("irq set", 32'h1, 32'(irq));
         chk("sck back idle", 32'(mode[1]), 32'(sck));
         rd(5'h10);
         chk("master data in", 32'hc3, got);
         rd(5'h0c);
         chk("flag cleared", 32'h0, got);
         chk("irq cleared", 32'h0, 32'(irq));
      end
      $display("test rates done");
   endtask
   task automatic t_collide();
      wr(5'h10, 8'h11);
      wr(5'h10, 8'h22);
      poll(7);
      chk("collision flag", 32'h1, 32'(got[6]));
      chk("second write lost", 32'h11, rx);
      rd(5'h10);
      rd(5'h0c);
      chk("collision cleared", 32'h0, got);
      $display("test collide done");
   endtask
   task automatic t_select();
      ss_n <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(5'h00);
      chk("master dropped", 32'h17, got);
      rd(5'h0c);
      chk("select flag", 32'h80, got);
      @(posedge mclk) irq_ack <= 1'b1;
      @(posedge mclk) irq_ack <= 1'b0;
      rd(5'h0c);
      chk("vector clears", 32'h0, got);
      ss_n <= 1'b1;
      wr(5'h04, 8'h04);
      wr(5'h00, 8'h37);
      ss_n <= 1'b0;
      repeat (6) @(posedge mclk);
      rd(5'h00);
      chk("select ignored", 32'h37, got);
      ss_n <= 1'b1;
      $display("test select done");
   endtask
   task automatic t_buffered();
      mode = 2'h0;
      wr(5'h04, 8'hc0);
      rd(5'h0c);
      chk("empty after enable", 32'h20, got);
      wr(5'h08, 8'hf0);
      rd(5'h08);
      chk("buffered enables", 32'hf0, got);
      chk("empty irq", 32'h1, 32'(irq));
      wr(5'h10, 8'h5a);
      wr(5'h10, 8'h6b);
      rd(5'h0c);
      chk("buffer held", 32'h0, 32'(got[5]));
      poll(6);
      chk("both bytes sent", 32'h6b, rx);
      chk("rx unread", 32'h1, 32'(got[7]));
      rd(5'h10);
      chk("rx stage two", 32'hc3, got);
      wr(5'h0c, 8'hc0);
      rd(5'h0c);
      chk("flags written clear", 32'h20, got);
      wr(5'h04, 8'h00);
      rd(5'h08);
      chk("enables hidden", 32'h0, got);
      $display("test buffered done");
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      t_reset();
      t_rates();
      t_collide();
      t_select();
      t_buffered();
      summarize();
   end
endmodule // tb_spcs_top
